// ---- src/irp_pkg.sv ----
`default_nettype none
package irp_pkg;

    // ==========================================================
    // Bus and clock
    // ==========================================================
    localparam int unsigned CLK_PERIOD_NS = 100;      // 10 MHz main oscillator
    localparam int unsigned AV_ADDR_W     = 8;        // Byte address
    localparam int unsigned AV_DATA_W     = 32;

    // ==========================================================
    // Register byte offsets
    // ==========================================================
    localparam logic [7:0] OFS_IRQ_MASK    = 8'h00;
    localparam logic [7:0] OFS_IRQ_FLAGS   = 8'h04;
    localparam logic [7:0] OFS_AUX_A       = 8'h08;
    localparam logic [7:0] OFS_AUX_B_LOW   = 8'h0c;
    localparam logic [7:0] OFS_AUX_B_HIGH  = 8'h10;
    localparam logic [7:0] OFS_CARRIER     = 8'h14;
    localparam logic [7:0] OFS_LOW_TIME    = 8'h18;
    localparam logic [7:0] OFS_HIGH_TIME   = 8'h1c;
    localparam logic [7:0] OFS_SCALE_CTRL  = 8'h20;
    localparam logic [7:0] OFS_MOD_CTRL    = 8'h24;
    localparam logic [7:0] OFS_TIMER_CTRL  = 8'h28;
    localparam logic [7:0] OFS_PORT_DIR    = 8'h2c;
    localparam logic [7:0] OFS_PORT_DATA   = 8'h30;

    // ==========================================================
    // Field positions and reset values
    // ==========================================================
    localparam int unsigned BIT_AUX_A_EN    = 0;      // Timer control register
    localparam int unsigned BIT_CARRIER_EN  = 2;
    localparam int unsigned BIT_AUX_B_EN    = 6;
    localparam int unsigned BIT_HIGH_BYTE   = 7;
    localparam int unsigned BIT_PIN         = 7;      // Port direction / data bit
    localparam int unsigned FLG_LOW_PULSE   = 7;      // Flag and mask positions
    localparam int unsigned FLG_HIGH_PULSE  = 6;
    localparam int unsigned FLG_CARRIER     = 5;
    localparam int unsigned FLG_AUX_B       = 4;
    localparam int unsigned FLG_AUX_A       = 3;
    localparam logic [7:0]  RST_ZERO        = 8'h00;
    localparam logic [7:0]  RST_PORT_DIR    = 8'h80;  // Pin starts as input
    localparam logic [7:0]  VEC_LOW_TIME    = 8'h15;
    localparam logic [7:0]  VEC_HIGH_TIME   = 8'h12;

    // ==========================================================
    // Register layouts and states
    // ==========================================================
    typedef struct packed {
        logic       scale_en;
        logic [2:0] scale_sel;
        logic       mod_en;
        logic       hf;
        logic       long_pulse_select;
        logic       out_sel;
    } irp_mod_ctrl_s;

    typedef struct packed {
        logic       high_en;
        logic [2:0] high_sel;
        logic       low_en;
        logic [2:0] low_sel;
    } irp_scale_ctrl_s;

    typedef enum logic [1:0] {
        PW_IDLE = 2'b00,
        PW_LOW  = 2'b01,
        PW_HIGH = 2'b10,
        PW_DONE = 2'b11
    } irp_pw_state_e;

    // Scaler mask: disabled gives 1:1, code n gives 1:2^(n+1)
    function automatic logic [7:0] irp_scale_mask(input logic en, input logic [2:0] sel);
        logic [8:0] m;
        m = (9'h002 << sel) - 9'h001;
        return en ? m[7:0] : 8'h00;
    endfunction

endpackage
`default_nettype wire

// ---- src/irp_timer_unit.sv ----
// Design decisions made here: the register addresses and the Avalon-MM register port.
`timescale 1ns/10ps
`default_nettype none
module irp_timer_unit (
    input  wire logic                          clk_sys_i,
    input  wire logic                          sys_rst_i,
    input  wire logic [irp_pkg::AV_ADDR_W-1:0] avs_address_i,
    input  wire logic                          avs_read_i,
    input  wire logic                          avs_write_i,
    input  wire logic [irp_pkg::AV_DATA_W-1:0] avs_writedata_i,
    input  wire logic [3:0]                    avs_byteenable_i,
    output logic      [irp_pkg::AV_DATA_W-1:0] avs_readdata_o,
    output logic                               avs_waitrequest_o,
    input  wire logic                          pin_i,
    output logic                               pin_o,
    output logic                               pin_oe_n_o,
    output logic                               irq_req_o,
    output logic      [7:0]                    irq_vector_o
);
    import irp_pkg::*;

    // ==========================================================
    // Registers and internal state
    // ==========================================================
    logic [7:0]      irq_mask;
    logic [7:0]      irq_flags;
    logic [7:0]      aux_a;
    logic [7:0]      aux_b_low;
    logic [7:0]      aux_b_high;
    logic [7:0]      carrier_count;
    logic [7:0]      low_time;
    logic [7:0]      high_time;
    irp_scale_ctrl_s scale_ctrl;
    irp_mod_ctrl_s   mod_ctrl;
    logic [7:0]      timer_ctrl;
    logic [7:0]      port_dir;
    logic [7:0]      port_data;
    logic [7:0]      carrier_phase;
    logic            carrier_level;
    irp_pw_state_e   pw_state;
    logic [7:0]      pw_cnt;
    logic [2:0]      pin_sync;
    logic            pin_level;
    logic [7:0]      ps_cnt  [3];
    logic [7:0]      ps_mask [3];
    logic [2:0]      ps_clr;
    logic [2:0]      ps_tick;

    // ==========================================================
    // Avalon slave: one wait cycle, then accept
    // ==========================================================
    logic       req;
    logic       acc_wr;
    logic [7:0] wdat;
    logic [7:0] rd_mux;
    assign req    = avs_read_i | avs_write_i;
    assign acc_wr = avs_write_i & ~avs_waitrequest_o & avs_byteenable_i[0];
    assign wdat   = avs_writedata_i[7:0];

    function automatic logic wr_hit(input logic w, input logic [7:0] a, input logic [7:0] ofs);
        return w && (a == ofs);
    endfunction

    // Read mux; flags come back gated by the mask
    always_comb begin
        case (avs_address_i)
            OFS_IRQ_MASK:   rd_mux = irq_mask;
            OFS_IRQ_FLAGS:  rd_mux = irq_flags & irq_mask;
            OFS_AUX_A:      rd_mux = aux_a;
            OFS_AUX_B_LOW:  rd_mux = aux_b_low;
            OFS_AUX_B_HIGH: rd_mux = aux_b_high;
            OFS_CARRIER:    rd_mux = carrier_count;
            OFS_LOW_TIME:   rd_mux = low_time;
            OFS_HIGH_TIME:  rd_mux = high_time;
            OFS_SCALE_CTRL: rd_mux = scale_ctrl;
            OFS_MOD_CTRL:   rd_mux = mod_ctrl;
            OFS_TIMER_CTRL: rd_mux = timer_ctrl;
            OFS_PORT_DIR:   rd_mux = port_dir;
            OFS_PORT_DATA:  rd_mux = {pin_level, port_data[BIT_PIN-1:0]};
            default:        rd_mux = RST_ZERO;                   // Unmapped reads zero
        endcase
    end

    // Waitrequest drops for exactly one cycle per request
    always_ff @(posedge clk_sys_i) begin
        if (sys_rst_i) begin
            avs_waitrequest_o <= 1'b1;
            avs_readdata_o    <= '0;
        end else begin
            avs_waitrequest_o <= ~(req & avs_waitrequest_o);
            if (avs_read_i && avs_waitrequest_o) begin
                avs_readdata_o <= {{(AV_DATA_W-8){1'b0}}, rd_mux};
            end
        end
    end

    // Plain control registers
    always_ff @(posedge clk_sys_i) begin
        if (sys_rst_i) begin
            irq_mask   <= RST_ZERO;
            low_time   <= RST_ZERO;
            high_time  <= RST_ZERO;
            scale_ctrl <= RST_ZERO;
            mod_ctrl   <= RST_ZERO;
            timer_ctrl <= RST_ZERO;
            port_dir   <= RST_PORT_DIR;
            port_data  <= RST_ZERO;
        end else begin
            if (wr_hit(acc_wr, avs_address_i, OFS_IRQ_MASK))   irq_mask   <= wdat;
            if (wr_hit(acc_wr, avs_address_i, OFS_LOW_TIME))   low_time   <= wdat;
            if (wr_hit(acc_wr, avs_address_i, OFS_HIGH_TIME))  high_time  <= wdat;
            if (wr_hit(acc_wr, avs_address_i, OFS_SCALE_CTRL)) scale_ctrl <= wdat;
            if (wr_hit(acc_wr, avs_address_i, OFS_MOD_CTRL))   mod_ctrl   <= wdat;
            if (wr_hit(acc_wr, avs_address_i, OFS_TIMER_CTRL)) timer_ctrl <= wdat;
            if (wr_hit(acc_wr, avs_address_i, OFS_PORT_DIR))   port_dir   <= wdat;
            if (wr_hit(acc_wr, avs_address_i, OFS_PORT_DATA))  port_data  <= wdat;
        end
    end

    // ==========================================================
    // Power-of-two scalers: carrier, high time, low time
    // ==========================================================
    assign ps_mask[0] = irp_scale_mask(mod_ctrl.scale_en, mod_ctrl.scale_sel);
    assign ps_mask[1] = irp_scale_mask(scale_ctrl.high_en, scale_ctrl.high_sel);
    assign ps_mask[2] = irp_scale_mask(scale_ctrl.low_en, scale_ctrl.low_sel);

    generate
        for (genvar g = 0; g < 3; g++) begin : g_scaler
            // Restart on segment start (carrier scaler: on a count write) so the first period is whole
            always_ff @(posedge clk_sys_i) begin
                if (sys_rst_i || ps_clr[g]) begin
                    ps_cnt[g] <= RST_ZERO;
                end else begin
                    ps_cnt[g] <= ps_cnt[g] + 8'h01;
                end
            end
            assign ps_tick[g] = (ps_cnt[g] & ps_mask[g]) == ps_mask[g];
        end
    endgenerate

    // ==========================================================
    // Auxiliary up timers A and B
    // ==========================================================
    logic wr_a, wr_bl, wr_bh, a_ovf, b_ovf, b_wide;
    assign wr_a   = wr_hit(acc_wr, avs_address_i, OFS_AUX_A);
    assign wr_bl  = wr_hit(acc_wr, avs_address_i, OFS_AUX_B_LOW);
    assign wr_bh  = wr_hit(acc_wr, avs_address_i, OFS_AUX_B_HIGH);
    assign b_wide = timer_ctrl[BIT_HIGH_BYTE];
    assign a_ovf  = timer_ctrl[BIT_AUX_A_EN] && !wr_a && (aux_a == '1);
    assign b_ovf  = timer_ctrl[BIT_AUX_B_EN] && !wr_bl && !wr_bh && (aux_b_low == '1)
                    && (!b_wide || aux_b_high == '1);

    // A software write wins over counting in the same cycle
    always_ff @(posedge clk_sys_i) begin
        if (sys_rst_i) begin
            aux_a <= RST_ZERO;
        end else if (wr_a) begin
            aux_a <= wdat;
        end else if (timer_ctrl[BIT_AUX_A_EN]) begin
            aux_a <= aux_a + 8'h01;
        end
    end

    // High byte only carries when enabled; otherwise it just holds
    always_ff @(posedge clk_sys_i) begin
        if (sys_rst_i) begin
            aux_b_low  <= RST_ZERO;
            aux_b_high <= RST_ZERO;
        end else begin
            if (wr_bl) begin
                aux_b_low <= wdat;
            end else if (timer_ctrl[BIT_AUX_B_EN] && !wr_bh) begin
                aux_b_low <= aux_b_low + 8'h01;
            end
            if (wr_bh) begin
                aux_b_high <= wdat;
            end else if (timer_ctrl[BIT_AUX_B_EN] && b_wide && !wr_bl && aux_b_low == '1) begin
                aux_b_high <= aux_b_high + 8'h01;
            end
        end
    end

    // ==========================================================
    // Carrier timer: scaled up timer or carrier generator
    // ==========================================================
    logic ir_mode, wr_c, c_ovf;
    assign ir_mode   = mod_ctrl.mod_en && mod_ctrl.hf;
    assign wr_c      = wr_hit(acc_wr, avs_address_i, OFS_CARRIER);
    assign ps_clr[0] = wr_c;
    assign c_ovf     = !ir_mode && timer_ctrl[BIT_CARRIER_EN] && ps_tick[0] && !wr_c
                       && (carrier_count == '1);

    // In IR mode the count register only holds the half period, less one scaled tick
    always_ff @(posedge clk_sys_i) begin
        if (sys_rst_i) begin
            carrier_count <= RST_ZERO;
            carrier_phase <= RST_ZERO;
            carrier_level <= 1'b1;
        end else if (wr_c) begin
            carrier_count <= wdat;
            carrier_phase <= RST_ZERO;
        end else if (ir_mode) begin
            if (ps_tick[0]) begin
                if (carrier_phase == carrier_count) begin
                    carrier_phase <= RST_ZERO;
                    carrier_level <= ~carrier_level;
                end else begin
                    carrier_phase <= carrier_phase + 8'h01;
                end
            end
        end else begin
            carrier_level <= 1'b1;
            carrier_phase <= RST_ZERO;
            if (timer_ctrl[BIT_CARRIER_EN] && ps_tick[0]) begin
                carrier_count <= carrier_count + 8'h01;
            end
        end
    end

    // ==========================================================
    // Pulse-width engine: low segment, then high segment
    // ==========================================================
    logic lo_unf, hi_unf, start_low, start_high, pwm_level;
    assign lo_unf     = (pw_state == PW_LOW) && ps_tick[2] && (pw_cnt == RST_ZERO);
    assign hi_unf     = (pw_state == PW_HIGH) && ps_tick[1] && (pw_cnt == RST_ZERO);
    assign start_low  = mod_ctrl.mod_en && ((pw_state == PW_IDLE) || hi_unf);
    assign start_high = mod_ctrl.mod_en && lo_unf && !mod_ctrl.long_pulse_select;
    assign ps_clr[1]  = start_high;
    assign ps_clr[2]  = start_low;

    // Each segment lasts (1 + value) scaled ticks
    always_ff @(posedge clk_sys_i) begin
        if (sys_rst_i || !mod_ctrl.mod_en) begin
            pw_state <= PW_IDLE;
            pw_cnt   <= RST_ZERO;
        end else begin
            case (pw_state)
                PW_IDLE: begin
                    pw_state <= PW_LOW;
                    pw_cnt   <= low_time;
                end
                PW_LOW: begin
                    if (lo_unf) begin
                        pw_state <= mod_ctrl.long_pulse_select ? PW_DONE : PW_HIGH;
                        pw_cnt   <= high_time;
                    end else if (ps_tick[2]) begin
                        pw_cnt <= pw_cnt - 8'h01;
                    end
                end
                PW_HIGH: begin
                    if (hi_unf) begin
                        pw_state <= PW_LOW;
                        pw_cnt   <= low_time;
                    end else if (ps_tick[1]) begin
                        pw_cnt <= pw_cnt - 8'h01;
                    end
                end
                PW_DONE: pw_state <= PW_DONE;                    // Single pulse stays high
                default: pw_state <= PW_IDLE;
            endcase
        end
    end

    // Low segment is steady low for PWM, carrier-gated for IR
    assign pwm_level = (pw_state == PW_LOW) ? (ir_mode & carrier_level) : 1'b1;

    // ==========================================================
    // Flags: hardware set wins over a software clear
    // ==========================================================
    logic [7:0] flag_set;
    always_comb begin
        flag_set                 = RST_ZERO;
        flag_set[FLG_LOW_PULSE]  = lo_unf;
        flag_set[FLG_HIGH_PULSE] = hi_unf;
        flag_set[FLG_CARRIER]    = c_ovf;
        flag_set[FLG_AUX_B]      = b_ovf;
        flag_set[FLG_AUX_A]      = a_ovf;
    end

    // Writing 0 clears a flag, writing 1 leaves it; writes never set
    always_ff @(posedge clk_sys_i) begin
        if (sys_rst_i) begin
            irq_flags <= RST_ZERO;
        end else if (wr_hit(acc_wr, avs_address_i, OFS_IRQ_FLAGS)) begin
            irq_flags <= (irq_flags & wdat) | flag_set;
        end else begin
            irq_flags <= irq_flags | flag_set;
        end
    end

    // Vector request; low-time source takes priority over high-time
    logic [7:0] pending;
    assign pending = irq_flags & irq_mask;
    always_ff @(posedge clk_sys_i) begin
        if (sys_rst_i) begin
            irq_req_o    <= 1'b0;
            irq_vector_o <= RST_ZERO;
        end else begin
            irq_req_o <= pending[FLG_LOW_PULSE] | pending[FLG_HIGH_PULSE];
            if (pending[FLG_LOW_PULSE]) begin
                irq_vector_o <= VEC_LOW_TIME;
            end else if (pending[FLG_HIGH_PULSE]) begin
                irq_vector_o <= VEC_HIGH_TIME;
            end else begin
                irq_vector_o <= RST_ZERO;
            end
        end
    end

    // ==========================================================
    // Shared pin: port bit or modulated output
    // ==========================================================
    // Third stage guards against a runt glitch on the raw pin
    always_ff @(posedge clk_sys_i) begin
        if (sys_rst_i) begin
            pin_sync  <= 3'b000;
            pin_level <= 1'b0;
        end else begin
            pin_sync <= {pin_sync[1:0], pin_i};
            if (pin_sync[1] == pin_sync[2]) begin
                pin_level <= pin_sync[2];
            end
        end
    end

    // Direction bit must be 0 for the modulator to reach the pin
    always_ff @(posedge clk_sys_i) begin
        if (sys_rst_i) begin
            pin_o      <= 1'b1;
            pin_oe_n_o <= 1'b1;
        end else begin
            pin_o      <= mod_ctrl.out_sel ? pwm_level : port_data[BIT_PIN];
            pin_oe_n_o <= port_dir[BIT_PIN];
        end
    end

    // ==========================================================
    // Checks
    // ==========================================================
    default clocking cb @(posedge clk_sys_i); endclocking
    default disable iff (sys_rst_i);

    sequence seq_low_end;
        (pw_state == PW_LOW) && ps_tick[2] && (pw_cnt == RST_ZERO);
    endsequence

    sequence seq_high_end;
        (pw_state == PW_HIGH) && ps_tick[1] && (pw_cnt == RST_ZERO);
    endsequence

    chk_pin_idle_high: assert property (
        (mod_ctrl.out_sel && !mod_ctrl.mod_en) [*2] |=> pin_o)
        else $error("modulated pin not high while modulator off");

    chk_pwm_low_out: assert property (
        (pw_state == PW_LOW && !mod_ctrl.hf && mod_ctrl.out_sel && mod_ctrl.mod_en) |=> !pin_o)
        else $error("pin not low during PWM low segment");

    chk_long_pulse: assert property (
        (seq_low_end and mod_ctrl.long_pulse_select && mod_ctrl.mod_en) |=> (pw_state == PW_DONE) [*2])
        else $error("long pulse did not end in the done state");

    chk_high_reload: assert property (
        (seq_low_end and !mod_ctrl.long_pulse_select && mod_ctrl.mod_en)
        |=> (pw_state == PW_HIGH) && (pw_cnt == $past(high_time)))
        else $error("high segment not loaded from high time");

    chk_flag_sticky: assert property (
        seq_high_end |=> irq_flags[FLG_HIGH_PULSE])
        else $error("high pulse underflow flag lost");

    chk_flag_read_and: assert property (
        (avs_read_i && avs_waitrequest_o && avs_address_i == OFS_IRQ_FLAGS)
        |=> avs_readdata_o[7:0] == $past(pending))
        else $error("flag read is not flags AND mask");

    chk_aux_a_stop: assert property (
        (!timer_ctrl[BIT_AUX_A_EN] && !wr_a) |=> $stable(aux_a))
        else $error("aux timer A moved while disabled");

    chk_aux_a_wrap: assert property (
        (timer_ctrl[BIT_AUX_A_EN] && !wr_a && aux_a == '1)
        |=> (aux_a == RST_ZERO) && irq_flags[FLG_AUX_A])
        else $error("aux timer A wrap not flagged");

    chk_vector_low: assert property (
        (pending[FLG_LOW_PULSE]) |=> irq_req_o && irq_vector_o == VEC_LOW_TIME)
        else $error("low time vector not presented");

    chk_bus_answer: assert property (
        (req && avs_waitrequest_o) |=> !avs_waitrequest_o ##1 avs_waitrequest_o)
        else $error("bus answer not one cycle after request");

endmodule // irp_timer_unit
`default_nettype wire

// ---- verification/irp_pin_load.sv ----
`timescale 1ns/10ps
`default_nettype none
// ==========
// Emitter load: resolves the pin and measures each level's width in cycles
module irp_pin_load (
    input  wire logic clk_i,
    input  wire logic drive_i,
    input  wire logic oe_n_i,
    output logic      level_o,
    output int        low_w_o,
    output int        high_w_o
);
    logic prev = 1'b1;
    int   run  = 0;
    // Pull-up holds the line high whenever the module lets go
    assign level_o = oe_n_i ? 1'b1 : drive_i;
    // Width is stored when the level changes, so a stuck pin keeps old widths
    always_ff @(posedge clk_i) begin
        prev <= level_o;
        if (level_o == prev) run <= run + 1;
        else begin
            run <= 1;
            if (prev) high_w_o <= run;
            else low_w_o <= run;
        end
    end
endmodule // irp_pin_load
`default_nettype wire

// ---- verification/test_irp_timer_unit.sv ----
`timescale 1ns/10ps
`default_nettype none
// ==========
// Register-level bench for the timer and modulator unit
module test_irp_timer_unit;
    import irp_pkg::*;
    logic clk = 1'b0, rst = 1'b1, rd = 1'b0, we = 1'b0;
    logic [7:0] adr = 8'h00, q;
    logic [31:0] wd = 32'h0, rdata;
    logic wait_o, pin_o, oe_n, lvl, irq;
    logic [7:0] vec;
    int low_w, high_w, miscompares = 0, comparisons = 0, cyc = 0;
    irp_timer_unit DUT (.clk_sys_i(clk), .sys_rst_i(rst), .avs_address_i(adr),
        .avs_read_i(rd), .avs_write_i(we), .avs_writedata_i(wd),
        .avs_byteenable_i(4'h1), .avs_readdata_o(rdata), .avs_waitrequest_o(wait_o),
        .pin_i(lvl), .pin_o(pin_o), .pin_oe_n_o(oe_n), .irq_req_o(irq), .irq_vector_o(vec));
    irp_pin_load load (.clk_i(clk), .drive_i(pin_o), .oe_n_i(oe_n), .level_o(lvl),
        .low_w_o(low_w), .high_w_o(high_w));
    initial forever #(CLK_PERIOD_NS / 2) clk = ~clk;
    // Hang guard: the whole run needs well under a thousand cycles
    always @(posedge clk) begin
        cyc <= cyc + 1;
        if (cyc == 5000) begin
            miscompares++;
            print_verdict();
        end
    end
    task automatic chk(input string nm, input logic [7:0] e, input logic [7:0] g);
        comparisons++;
        if (g !== e) begin
            miscompares++;
            $display("mismatch %s expected %h seen %h", nm, e, g);
        end
    endtask
    // One Avalon transfer; an idle edge first keeps releases and raises apart
    task automatic bus(input logic w, input logic [7:0] a, input logic [7:0] d);
        @(posedge clk);
        adr <= a;
        wd <= {24'h0, d};
        rd <= !w;
        we <= w;
        do @(posedge clk); while (wait_o !== 1'b0);
        q = rdata[7:0];
        rd <= 1'b0;
        we <= 1'b0;
    endtask
    task automatic rchk(input string nm, input logic [7:0] a, input logic [7:0] e);
        bus(1'b0, a, 8'h00);
        chk(nm, e, q);
    endtask
    task automatic print_verdict();
        $display("comparisons %0d miscompares %0d", comparisons, miscompares);
        if (miscompares == 0 && comparisons > 0) $display("All tests passed");
        else $display("Some tests failed");
        $finish;
    endtask
    initial begin
        repeat (6) @(posedge clk);
        rst <= 1'b0;
        rchk("mask", OFS_IRQ_MASK, RST_ZERO);
        rchk("dir", OFS_PORT_DIR, RST_PORT_DIR);
        rchk("unmapped", 8'h40, 8'h00);
        $display("test reset done");
        bus(1'b1, OFS_AUX_A, 8'h10);
        repeat (5) @(posedge clk);
        rchk("aux_a stopped", OFS_AUX_A, 8'h10);
        bus(1'b1, OFS_AUX_A, 8'hfd);
        bus(1'b1, OFS_IRQ_MASK, 8'h08);
        bus(1'b1, OFS_TIMER_CTRL, 8'h01);
        repeat (8) @(posedge clk);
        rchk("aux_a flag", OFS_IRQ_FLAGS, 8'h08);
        $display("test timer done");
        bus(1'b1, OFS_PORT_DIR, 8'h00);
        bus(1'b1, OFS_MOD_CTRL, 8'h01);
        repeat (3) @(posedge clk);
        chk("pin idle", 8'h01, {7'h0, lvl});
        bus(1'b1, OFS_LOW_TIME, 8'h02);
        bus(1'b1, OFS_HIGH_TIME, 8'h03);
        bus(1'b1, OFS_IRQ_MASK, 8'hc0);
        bus(1'b1, OFS_MOD_CTRL, 8'h09);
        repeat (30) @(posedge clk);
        chk("low width", 8'd3, low_w[7:0]);
        chk("high width", 8'd4, high_w[7:0]);
        chk("vector", VEC_LOW_TIME, vec);
        rchk("pwm flags", OFS_IRQ_FLAGS, 8'hc0);
        // Masking off the low source must hand the request to the high one
        bus(1'b1, OFS_IRQ_MASK, 8'h40);
        repeat (3) @(posedge clk);
        chk("high vector", VEC_HIGH_TIME, vec);
        chk("irq", 8'h01, {7'h0, irq});
        bus(1'b1, OFS_SCALE_CTRL, 8'h08);
        repeat (40) @(posedge clk);
        chk("scaled low", 8'd6, low_w[7:0]);
        $display("test pwm done");
        // Carrier half period of two cycles inside one long low segment
        bus(1'b1, OFS_CARRIER, 8'h01);
        bus(1'b1, OFS_LOW_TIME, 8'h3f);
        bus(1'b1, OFS_MOD_CTRL, 8'h0d);
        repeat (60) @(posedge clk);
        chk("carrier low", 8'd2, low_w[7:0]);
        chk("carrier high", 8'd2, high_w[7:0]);
        $display("test carrier done");
        // Long pulse: one scaled low of (1+4)*2 cycles, then high for good
        bus(1'b1, OFS_MOD_CTRL, 8'h01);
        bus(1'b1, OFS_IRQ_FLAGS, 8'h00);
        bus(1'b1, OFS_IRQ_MASK, 8'hc0);
        bus(1'b1, OFS_LOW_TIME, 8'h04);
        bus(1'b1, OFS_MOD_CTRL, 8'h0b);
        repeat (40) @(posedge clk);
        chk("single low", 8'd10, low_w[7:0]);
        chk("pin after pulse", 8'h01, {7'h0, lvl});
        rchk("single flags", OFS_IRQ_FLAGS, 8'h80);
        $display("test single pulse done");
        // Timer B as 16 bits and carrier as plain up timer both wrap
        bus(1'b1, OFS_IRQ_MASK, 8'h30);
        bus(1'b1, OFS_AUX_B_HIGH, 8'hff);
        bus(1'b1, OFS_AUX_B_LOW, 8'hfe);
        bus(1'b1, OFS_CARRIER, 8'hfc);
        bus(1'b1, OFS_TIMER_CTRL, 8'hc5);
        repeat (20) @(posedge clk);
        rchk("b high wrap", OFS_AUX_B_HIGH, 8'h00);
        rchk("b c flags", OFS_IRQ_FLAGS, 8'h30);
        $display("test timers done");
        print_verdict();
    end
endmodule // test_irp_timer_unit
`default_nettype wire
